// [ddtp_pkg.sv]
// Constants, register layouts and types of the DDR2 timing and priority block.
// Assumes one clock domain; every figure below is shared by design and bench.
package ddtp_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h08;
  localparam logic [7:0] OFF_TIM1 = 8'h10;
  localparam logic [7:0] OFF_TIM2 = 8'h14;
  localparam logic [7:0] OFF_PRIO = 8'h20;
  localparam logic [7:0] OFF_CTRL = 8'he4;

  // Reset values
  localparam logic [31:0] RST_CONFIG = 32'h00000a00;
  localparam logic [31:0] RST_TIM1 = 32'h7ffffffb;
  localparam logic [31:0] RST_TIM2 = 32'h01ffffff;
  localparam logic [31:0] RST_PRIO = 32'h000000ff;
  localparam logic [31:0] RST_CTRL = 32'h00000006;

  // Writable bits; all others read back as stored reset value or zero
  localparam logic [31:0] WM_CONFIG = 32'h00018e00;
  localparam logic [31:0] WM_TIM1 = 32'hfffffffb;
  localparam logic [31:0] WM_TIM2 = 32'h01ffffff;
  localparam logic [31:0] WM_PRIO = 32'h000000ff;
  localparam logic [31:0] WM_CTRL = 32'h00000027;

  // Field positions
  localparam int CFG_UNLOCK_BIT = 15;
  localparam int CFG_ENABLE_BIT = 16;
  localparam int CFG_CL_LSB = 9;
  localparam int CTL_IFRST_BIT = 5;
  localparam int STAT_RDY_BIT = 2;
  localparam logic [31:0] STAT_FIXED = 32'h40000000;
  localparam logic [7:0] PRIO_DISABLE = 8'hff;

  typedef struct packed {
    logic [6:0] rfc;
    logic [2:0] rp;
    logic [2:0] rcd;
    logic [2:0] wr;
    logic [4:0] ras;
    logic [4:0] rc;
    logic [2:0] rrd;
    logic rsvd;
    logic [1:0] wtr;
  } ddtp_tim1_t;

  typedef struct packed {
    logic [6:0] rsvd;
    logic [1:0] odt;
    logic [6:0] sxnr;
    logic [7:0] sxrd;
    logic [2:0] rtp;
    logic [4:0] cke;
  } ddtp_tim2_t;

  typedef enum logic [2:0] {
    CMD_REF = 3'h0,
    CMD_LMR = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_RD = 3'h4,
    CMD_WR = 3'h5
  } ddtp_kind_t;

  typedef struct packed {
    logic issue;
    ddtp_kind_t kind;
  } ddtp_cmd_t;

  // Interval timer indices
  localparam int TM_RFC = 0;
  localparam int TM_RP = 1;
  localparam int TM_RCD = 2;
  localparam int TM_WR = 3;
  localparam int TM_RAS = 4;
  localparam int TM_RC = 5;
  localparam int TM_RRD = 6;
  localparam int TM_WTR = 7;
  localparam int TM_RTP = 8;
  localparam int TM_SXNR = 9;
  localparam int TM_SXRD = 10;
  localparam int TM_CKE = 11;
  localparam int TM_ODT = 12;
  localparam int TM_NUM = 13;

  typedef enum logic [2:0] {
    WS_IDLE = 3'b001,
    WS_LEAD = 3'b010,
    WS_DATA = 3'b100
  } ddtp_wstate_t;

endpackage

// [ddtp_timing_cfg.sv]
// Timing, priority and interface-reset registers of a DDR2 controller, with the
// interval timers that gate each command kind toward the SDRAM.
// Assumes a scheduler on the same clock that issues only allowed commands.
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps

// What this block does
// - Timing register writes land only while the timing unlock bit is set.
// - Refresh or load-mode blocks refresh and activate for refresh-recovery plus one.
// - Precharge blocks refresh and activate for precharge period plus one.
// - Activate blocks read and write for activate-to-access plus one.
// - Last write data blocks precharge for write recovery plus one.
// - Changing write recovery while enabled starts SDRAM initialization.
// - Activate blocks precharge for active period plus one.
// - Activates spaced by row cycle plus one.
// - Activates to other banks spaced by bank-to-bank plus one; software formula.
// - Last write blocks read for write-to-read plus one.
// - Termination asserted the programmed cycles before write data; software bounds it.
// - Self-refresh exit blocks non-read commands for exit field plus one.
// - Self-refresh exit blocks reads for read exit field plus one.
// - Read blocks precharge for read-to-precharge plus one.
// - Clock enable stays stable clock-enable field plus one between changes.
// - Oldest entry raised after priority field plus one transfers.
// - Priority field all ones disables the raise.
// - Interface logic held in reset while the interface reset bit is one.
// - Ready flag set only when interface logic is locked and out of reset.
// - Unlock bit one permits timing writes; writing it starts initialization.
module ddtp_timing_cfg
  import ddtp_pkg::*;
#(
  parameter int BURST_CYC = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire ddtp_cmd_t cmd_i,
  output logic [5:0] cmd_allow_o,
  input wire logic cke_req_i,
  output logic mem_cke_o,
  output logic odt_o,
  output logic wdata_en_o,
  input wire logic xfer_done_i,
  input wire logic oldest_retire_i,
  output logic starvation_transfer_count_o,
  input wire logic phy_locked_i,
  output logic phy_rst_o,
  output logic [2:0] read_latency_o,
  output logic [2:0] cas_latency_o,
  output logic init_start_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] wm);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
    return (old & ~m) | (wd & m);
  endfunction

  function automatic logic [7:0] tick(input logic [7:0] cnt, input logic ld,
                                      input logic [7:0] val);
    if (ld) begin
      return val;
    end
    return (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
  endfunction

  logic ws_r;
  logic [31:0] rdata_r;
  logic [31:0] cfg_r;
  ddtp_tim1_t t1_r;
  ddtp_tim2_t t2_r;
  logic [7:0] prio_r;
  logic [31:0] ctl_r;
  logic lk_s1_r;
  logic lk_s2_r;
  logic rdy_r;
  logic init_r;
  logic wr_acc;
  logic [5:0] wsel;
  logic unlock;
  ddtp_tim1_t t1_nxt;
  logic [31:0] prio_wr;

  assign wr_acc = avs_write_i & ~ws_r;
  assign wsel = avs_address_i[7:2];
  assign unlock = cfg_r[CFG_UNLOCK_BIT];
  assign t1_nxt = ddtp_tim1_t'(merge(t1_r, avs_writedata_i, avs_byteenable_i, WM_TIM1));
  assign prio_wr = merge({24'h000000, prio_r}, avs_writedata_i, avs_byteenable_i, WM_PRIO);

  function automatic logic [31:0] rd_mux(input logic [5:0] a);
    unique case (a)
      OFF_STATUS[7:2]: rd_mux = STAT_FIXED | (32'(rdy_r) << STAT_RDY_BIT);
      OFF_CONFIG[7:2]: rd_mux = cfg_r;
      OFF_TIM1[7:2]: rd_mux = t1_r;
      OFF_TIM2[7:2]: rd_mux = t2_r;
      OFF_PRIO[7:2]: rd_mux = {24'h000000, prio_r};
      OFF_CTRL[7:2]: rd_mux = ctl_r;
      default: rd_mux = 32'h00000000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One wait state per access keeps read data a plain register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ws_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else if (ce_i) begin
      if ((avs_read_i | avs_write_i) & ws_r) begin
        ws_r <= 1'b0;
        rdata_r <= avs_read_i ? rd_mux(wsel) : 32'h00000000;
      end else begin
        ws_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_r <= RST_CONFIG;
      prio_r <= RST_PRIO[7:0];
      ctl_r <= RST_CTRL;
    end else if (ce_i && wr_acc) begin
      if (wsel == OFF_CONFIG[7:2]) begin
        cfg_r <= merge(cfg_r, avs_writedata_i, avs_byteenable_i, WM_CONFIG);
      end
      if (wsel == OFF_PRIO[7:2]) begin
        prio_r <= prio_wr[7:0];
      end
      if (wsel == OFF_CTRL[7:2]) begin
        ctl_r <= merge(ctl_r, avs_writedata_i, avs_byteenable_i, WM_CTRL);
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      t1_r <= ddtp_tim1_t'(RST_TIM1);
      t2_r <= ddtp_tim2_t'(RST_TIM2);
    end else if (ce_i && wr_acc && unlock) begin
      if (wsel == OFF_TIM1[7:2]) begin
        t1_r <= t1_nxt;
      end
      if (wsel == OFF_TIM2[7:2]) begin
        t2_r <= ddtp_tim2_t'(merge(t2_r, avs_writedata_i, avs_byteenable_i, WM_TIM2));
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      init_r <= 1'b0;
    end else if (ce_i) begin
      init_r <= wr_acc && ((wsel == OFF_CONFIG[7:2]) ||
                (wsel == OFF_TIM1[7:2] && unlock && cfg_r[CFG_ENABLE_BIT] &&
                 t1_nxt.wr != t1_r.wr));
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lk_s1_r <= 1'b0;
      lk_s2_r <= 1'b0;
      rdy_r <= 1'b0;
    end else if (ce_i) begin
      lk_s1_r <= phy_locked_i;
      lk_s2_r <= lk_s1_r;
      rdy_r <= lk_s2_r & ~ctl_r[CTL_IFRST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] cnt_r [TM_NUM];
  logic [7:0] cnt_nxt [TM_NUM];
  logic [7:0] val [TM_NUM];
  logic [TM_NUM-1:0] ld;
  ddtp_wstate_t wst_r;
  ddtp_wstate_t wst_nxt;
  logic [7:0] bcnt_r;
  logic cke_r;
  logic cke_go;
  logic odt_r;
  logic wde_r;
  logic [5:0] allow_r;
  logic burst_end;

  function automatic logic is_k(input ddtp_cmd_t c, input ddtp_kind_t k);
    return c.issue && c.kind == k;
  endfunction

  // clock enable moves only when its timer is idle
  assign cke_go = (cke_req_i != cke_r) && cnt_r[TM_CKE] == 8'h00;
  assign burst_end = (wst_r == WS_DATA) && bcnt_r == 8'h00;

  always_comb begin
    val[TM_RFC] = 8'(t1_r.rfc);
    val[TM_RP] = 8'(t1_r.rp);
    val[TM_RCD] = 8'(t1_r.rcd);
    val[TM_WR] = 8'(t1_r.wr);
    val[TM_RAS] = 8'(t1_r.ras);
    val[TM_RC] = 8'(t1_r.rc);
    val[TM_RRD] = 8'(t1_r.rrd);
    val[TM_WTR] = 8'(t1_r.wtr);
    val[TM_RTP] = 8'(t2_r.rtp);
    val[TM_SXNR] = 8'(t2_r.sxnr);
    val[TM_SXRD] = t2_r.sxrd;
    val[TM_CKE] = 8'(t2_r.cke);
    val[TM_ODT] = 8'(t2_r.odt);
    ld = '0;
    ld[TM_RFC] = is_k(cmd_i, CMD_REF) | is_k(cmd_i, CMD_LMR);
    ld[TM_RP] = is_k(cmd_i, CMD_PRE);
    ld[TM_RCD] = is_k(cmd_i, CMD_ACT);
    ld[TM_RAS] = is_k(cmd_i, CMD_ACT);
    ld[TM_RC] = is_k(cmd_i, CMD_ACT);
    ld[TM_RRD] = is_k(cmd_i, CMD_ACT);
    ld[TM_RTP] = is_k(cmd_i, CMD_RD);
    ld[TM_WR] = burst_end;
    ld[TM_WTR] = burst_end;
    ld[TM_SXNR] = cke_go & cke_req_i;
    ld[TM_SXRD] = cke_go & cke_req_i;
    ld[TM_CKE] = cke_go;
    ld[TM_ODT] = is_k(cmd_i, CMD_WR);
    for (int i = 0; i < TM_NUM; i++) begin
      cnt_nxt[i] = tick(cnt_r[i], ld[i], val[i]);
    end
  end

  // termination leads write data by the programmed cycles
  always_comb begin
    wst_nxt = wst_r;
    unique case (wst_r)
      WS_IDLE: begin
        if (is_k(cmd_i, CMD_WR)) begin
          wst_nxt = (t2_r.odt == 2'h0) ? WS_DATA : WS_LEAD;
        end
      end
      WS_LEAD: begin
        if (cnt_r[TM_ODT] <= 8'h01) begin
          wst_nxt = WS_DATA;
        end
      end
      WS_DATA: begin
        if (bcnt_r == 8'h00) begin
          wst_nxt = WS_IDLE;
        end
      end
      default: wst_nxt = WS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < TM_NUM; i++) begin
        cnt_r[i] <= 8'h00;
      end
    end else if (ce_i) begin
      for (int i = 0; i < TM_NUM; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wst_r <= WS_IDLE;
      bcnt_r <= 8'h00;
      odt_r <= 1'b0;
      wde_r <= 1'b0;
    end else if (ce_i) begin
      wst_r <= wst_nxt;
      odt_r <= wst_nxt != WS_IDLE;
      wde_r <= wst_nxt == WS_DATA;
      if (wst_r != WS_DATA && wst_nxt == WS_DATA) begin
        bcnt_r <= 8'(BURST_CYC - 1);
      end else if (bcnt_r != 8'h00) begin
        bcnt_r <= bcnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cke_r <= 1'b0;
    end else if (ce_i && cke_go) begin
      cke_r <= cke_req_i;
    end
  end

  // Allows are registered from next counter values, so they are exact, not late
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      allow_r <= 6'h00;
    end else if (ce_i) begin
      allow_r[CMD_REF] <= cnt_nxt[TM_RFC] == 8'h00 && cnt_nxt[TM_RP] == 8'h00 &&
                          cnt_nxt[TM_SXNR] == 8'h00;
      allow_r[CMD_LMR] <= cnt_nxt[TM_SXNR] == 8'h00;
      allow_r[CMD_PRE] <= cnt_nxt[TM_RAS] == 8'h00 && cnt_nxt[TM_WR] == 8'h00 &&
                          cnt_nxt[TM_RTP] == 8'h00 && cnt_nxt[TM_SXNR] == 8'h00 &&
                          wst_nxt == WS_IDLE;
      allow_r[CMD_ACT] <= cnt_nxt[TM_RFC] == 8'h00 && cnt_nxt[TM_RP] == 8'h00 &&
                          cnt_nxt[TM_RC] == 8'h00 && cnt_nxt[TM_RRD] == 8'h00 &&
                          cnt_nxt[TM_SXNR] == 8'h00;
      allow_r[CMD_RD] <= cnt_nxt[TM_RCD] == 8'h00 && cnt_nxt[TM_WTR] == 8'h00 &&
                         cnt_nxt[TM_SXRD] == 8'h00 && wst_nxt == WS_IDLE;
      allow_r[CMD_WR] <= cnt_nxt[TM_RCD] == 8'h00 && cnt_nxt[TM_SXNR] == 8'h00 &&
                         wst_nxt == WS_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] xcnt_r;
  logic raise_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      xcnt_r <= 8'h00;
      raise_r <= 1'b0;
    end else if (ce_i) begin
      raise_r <= xfer_done_i && prio_r != PRIO_DISABLE && xcnt_r == prio_r;
      if (oldest_retire_i || (xfer_done_i && xcnt_r == prio_r)) begin
        xcnt_r <= 8'h00;
      end else if (xfer_done_i && prio_r != PRIO_DISABLE) begin
        xcnt_r <= xcnt_r + 8'h01;
      end
    end
  end

  // interface reset straight from the control bit
  assign phy_rst_o = ctl_r[CTL_IFRST_BIT];
  assign read_latency_o = ctl_r[2:0];
  assign cas_latency_o = cfg_r[CFG_CL_LSB+:3];
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = ws_r;
  assign cmd_allow_o = allow_r;
  assign mem_cke_o = cke_r;
  assign odt_o = odt_r;
  assign wdata_en_o = wde_r;
  assign starvation_transfer_count_o = raise_r;
  assign init_start_o = init_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic t1_hit;
  assign t1_hit = ce_i && wr_acc && wsel == OFF_TIM1[7:2];

  property p_lock;
    t1_hit && !unlock |=> $stable(t1_r);
  endproperty
  a_lock: assert property (p_lock) else $error("timing written while locked");

  property p_rfc;
    ce_i && is_k(cmd_i, CMD_REF) && t1_r.rfc != 7'h00 |=> !cmd_allow_o[CMD_ACT];
  endproperty
  a_rfc: assert property (p_rfc) else $error("activate allowed after refresh");

  property p_rcd;
    ce_i && is_k(cmd_i, CMD_ACT) |=> cmd_allow_o[CMD_RD] == 1'b0 || $past(t1_r.rcd) == 3'h0;
  endproperty
  a_rcd: assert property (p_rcd) else $error("read allowed inside activate delay");

  property p_init;
    t1_hit && unlock && cfg_r[CFG_ENABLE_BIT] && t1_nxt.wr != t1_r.wr |=> init_start_o;
  endproperty
  a_init: assert property (p_init) else $error("no init on recovery change");

  property p_nostarve;
    prio_r == PRIO_DISABLE |=> !starvation_transfer_count_o;
  endproperty
  a_nostarve: assert property (p_nostarve) else $error("raise while disabled");

  property p_rdy;
    ctl_r[CTL_IFRST_BIT] |=> !rdy_r;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready during interface reset");

  sequence s_cke_move;
    ce_i && cke_go && t2_r.cke != 5'h00;
  endsequence
  property p_cke;
    s_cke_move ##1 ce_i |=> $stable(mem_cke_o);
  endproperty
  a_cke: assert property (p_cke) else $error("clock enable toggled too soon");

  sequence s_wr_lead;
    ce_i && wst_r == WS_IDLE && is_k(cmd_i, CMD_WR) && t2_r.odt != 2'h0;
  endsequence
  // Any nonzero lead must open with termination on and write data still off
  property p_odt;
    s_wr_lead |=> odt_o && !wdata_en_o;
  endproperty
  a_odt: assert property (p_odt) else $error("write data before termination lead");

  property p_wtr;
    ce_i && burst_end && t1_r.wtr != 2'h0 |=> !cmd_allow_o[CMD_RD];
  endproperty
  a_wtr: assert property (p_wtr) else $error("read allowed after write data");

endmodule

// [ddtp_sdram_model.sv]
// Far-side model: interface logic lock and SDRAM data transfers.
// Assumes the block's clock and reset; lock is lost while interface reset is high.
`timescale 1ns/10ps
module ddtp_sdram_model #(
  parameter int LOCK_CYC = 5
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic phy_rst_i,
  input wire logic wdata_en_i,
  output logic phy_locked_o,
  output logic xfer_done_o
);
  int cnt_r;

  // Lock comes only after reset has stood released for a while
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      cnt_r <= 0;
    else if (phy_rst_i)
      cnt_r <= 0;
    else if (cnt_r < LOCK_CYC)
      cnt_r <= cnt_r + 1;
  end
  assign phy_locked_o = (cnt_r == LOCK_CYC);
  // One memory transfer per write data cycle
  assign xfer_done_o = wdata_en_i;
endmodule

// [ddtp_timing_cfg_bench.sv]
// Self-checking bench of the timing, priority and interface-reset block.
// Assumes the block answers Avalon-MM accesses and gates commands by allow levels.
`timescale 1ns/10ps
module ddtp_timing_cfg_bench
  import ddtp_pkg::*;
;
  localparam int W = 30;
  localparam int BC = 4;
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic ce_i = 1'h1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  ddtp_cmd_t cmd_i = '{1'h0, CMD_REF};
  logic cke_req_i = 1'h0;
  logic oldest_retire_i = 1'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [5:0] cmd_allow_o;
  logic mem_cke_o, odt_o, wdata_en_o, xfer_done, starvation_transfer_count_o;
  logic phy_locked, phy_rst_o, init_start_o;
  logic [2:0] read_latency_o, cas_latency_o;
  int fails = 0;
  int n_tests = 0;
  int n_init = 0;
  int n_raise = 0;
  int zc[6];
  int za[6];
  int n_lead, n_data, n_cke;
  logic [31:0] q[$];
  ddtp_tim1_t f1;
  ddtp_tim2_t f2;

  always #12.5 clk_i = ~clk_i;

  ddtp_timing_cfg #(.BURST_CYC(BC)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .cmd_i(cmd_i),
    .cmd_allow_o(cmd_allow_o), .cke_req_i(cke_req_i), .mem_cke_o(mem_cke_o), .odt_o(odt_o),
    .wdata_en_o(wdata_en_o), .xfer_done_i(xfer_done), .oldest_retire_i(oldest_retire_i),
    .starvation_transfer_count_o(starvation_transfer_count_o), .phy_locked_i(phy_locked), .phy_rst_o(phy_rst_o),
    .read_latency_o(read_latency_o), .cas_latency_o(cas_latency_o),
    .init_start_o(init_start_o));

  ddtp_sdram_model #(.LOCK_CYC(5)) u_mem (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .phy_rst_i(phy_rst_o), .wdata_en_i(wdata_en_o), .phy_locked_o(phy_locked),
    .xfer_done_o(xfer_done));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= b;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 20);
    if (n >= 20)
      fails++;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'h0, a, 32'h0, 4'hf);
  endtask

  // Read data is compared against the oldest note when the answer stands
  always @(posedge clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'h0 && q.size() > 0)
      check(avs_readdata_o, q.pop_front());
    if (init_start_o === 1'h1)
      n_init++;
    if (starvation_transfer_count_o === 1'h1)
      n_raise++;
  end

  // Counts blocked cycles of each kind, from now and from the end of write data
  task automatic watch(input bit now);
    bit run[6];
    bit ra[6];
    bit seen, rc;
    for (int b = 0; b < 6; b++) begin
      zc[b] = 0;
      za[b] = 0;
      run[b] = 1;
      ra[b] = 1;
    end
    n_lead = 0;
    n_data = 0;
    n_cke = 0;
    seen = 0;
    rc = 1;
    for (int i = 0; i < W; i++) begin
      if (i > 0 || !now)
        @(posedge clk_i);
      if (mem_cke_o !== 1'h1)
        rc = 0;
      if (rc)
        n_cke++;
      if (odt_o === 1'h1 && wdata_en_o !== 1'h1 && !seen)
        n_lead++;
      if (wdata_en_o === 1'h1) begin
        n_data++;
        seen = 1;
      end
      for (int b = 0; b < 6; b++) begin
        if (cmd_allow_o[b] !== 1'h0)
          run[b] = 0;
        if (run[b])
          zc[b]++;
        if (seen && wdata_en_o !== 1'h1 && cmd_allow_o[b] !== 1'h0)
          ra[b] = 0;
        if (seen && wdata_en_o !== 1'h1 && ra[b])
          za[b]++;
      end
    end
  endtask

  // The scheduler side only issues a kind once it is allowed
  task automatic fire(input ddtp_kind_t k);
    int n;
    n = 0;
    while (cmd_allow_o[k] !== 1'h1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40)
      fails++;
    @(posedge clk_i);
    cmd_i <= '{1'h1, k};
    @(posedge clk_i);
    cmd_i <= '{1'h0, CMD_REF};
    watch(0);
  endtask

  initial begin
    #125000;
    fails++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int e;
    logic [7:0] v;
    e = $urandom(32'h5923e149);
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    rd(OFF_CONFIG, RST_CONFIG);
    rd(OFF_TIM1, RST_TIM1);
    rd(OFF_TIM2, RST_TIM2);
    rd(OFF_PRIO, RST_PRIO);
    rd(OFF_CTRL, RST_CTRL);
    rd(8'h40, 32'h0);
    f1 = '0;
    f1.rfc = 7'(1 + $urandom % 8);
    f1.rcd = 3'(1 + $urandom % 4);
    // active period kept at least activate-to-access
    f1.ras = 5'(f1.rcd + $urandom % 8);
    f1.rp = 3'(1 + $urandom % 7);
    f1.wr = 3'(1 + $urandom % 6);
    f1.rc = 5'(1 + $urandom % 12);
    f1.rrd = 3'($urandom % 8);
    f1.wtr = 2'($urandom % 4);
    f2 = '0;
    // termination lead kept below CAS latency minus one
    f2.odt = 2'($urandom % 4);
    f2.sxnr = 7'(1 + $urandom % 12);
    f2.sxrd = 8'(1 + $urandom % 12);
    f2.rtp = 3'($urandom % 8);
    f2.cke = 5'(1 + $urandom % 6);
    // Locked timing registers keep their contents
    bus(1'h1, OFF_TIM1, $urandom, 4'hf);
    bus(1'h1, OFF_TIM2, $urandom, 4'hf);
    rd(OFF_TIM1, RST_TIM1);
    rd(OFF_TIM2, RST_TIM2);
    e = n_init;
    bus(1'h1, OFF_CONFIG, 32'h00018a00, 4'hf);
    repeat (2) @(posedge clk_i);
    check(n_init, e + 1);
    check(cas_latency_o, 3'h5);
    // read latency set to CAS latency plus one
    check(read_latency_o, 3'h6);
    e = n_init;
    bus(1'h1, OFF_TIM1, f1, 4'hf);
    repeat (2) @(posedge clk_i);
    check(n_init, e + 1);
    rd(OFF_TIM1, f1 & WM_TIM1);
    bus(1'h1, OFF_TIM1, f1, 4'hf);
    repeat (2) @(posedge clk_i);
    check(n_init, e + 1);
    bus(1'h1, OFF_TIM2, f2, 4'hf);
    rd(OFF_TIM2, f2 & WM_TIM2);
    // Self-refresh exit, then an early request to drop clock enable
    @(posedge clk_i);
    cke_req_i <= 1'h1;
    e = 0;
    while (mem_cke_o !== 1'h1 && e < 40) begin
      @(posedge clk_i);
      e++;
    end
    cke_req_i <= 1'h0;
    watch(1);
    check(zc[CMD_ACT], f2.sxnr);
    check(zc[CMD_RD], f2.sxrd);
    check(n_cke >= f2.cke + 1, 1'h1);
    check(n_cke < W, 1'h1);
    cke_req_i <= 1'h1;
    repeat (W) @(posedge clk_i);
    fire(CMD_REF);
    check(zc[CMD_ACT], f1.rfc);
    check(zc[CMD_REF], f1.rfc);
    fire(CMD_LMR);
    check(zc[CMD_ACT], f1.rfc);
    fire(CMD_ACT);
    check(zc[CMD_RD], f1.rcd);
    check(zc[CMD_WR], f1.rcd);
    check(zc[CMD_PRE], f1.ras);
    check(zc[CMD_ACT], (f1.rc > f1.rrd) ? f1.rc : f1.rrd);
    fire(CMD_PRE);
    check(zc[CMD_ACT], f1.rp);
    check(zc[CMD_REF], f1.rp);
    fire(CMD_WR);
    check(n_lead, f2.odt);
    check(n_data, BC);
    check(za[CMD_PRE], f1.wr);
    check(za[CMD_RD], f1.wtr);
    fire(CMD_RD);
    check(zc[CMD_PRE], f2.rtp);
    for (int p = 0; p < 3; p++) begin
      v = (p == 0) ? 8'h01 : (p == 1) ? 8'h03 : PRIO_DISABLE;
      bus(1'h1, OFF_PRIO, {24'hffffff, v}, 4'hf);
      rd(OFF_PRIO, {24'h0, v});
      // Oldest entry leaves, so the starvation count restarts
      @(posedge clk_i);
      oldest_retire_i <= 1'h1;
      @(posedge clk_i);
      oldest_retire_i <= 1'h0;
      e = n_raise;
      fire(CMD_WR);
      fire(CMD_WR);
      check(n_raise - e, (v == PRIO_DISABLE) ? 0 : 8 / (v + 1));
    end
    // Clock enable low must freeze the clock-enable output despite a new request
    ce_i <= 1'h0;
    cke_req_i <= 1'h0;
    repeat (W) @(posedge clk_i);
    check(mem_cke_o, 1'h1);
    ce_i <= 1'h1;
    repeat (W) @(posedge clk_i);
    check(mem_cke_o, 1'h0);
    cke_req_i <= 1'h1;
    repeat (W) @(posedge clk_i);
    check(mem_cke_o, 1'h1);
    bus(1'h1, OFF_PRIO, 32'h0, 4'h0);
    rd(OFF_PRIO, 32'h000000ff);
    bus(1'h1, OFF_CTRL, 32'h00000026, 4'hf);
    @(posedge clk_i);
    check(phy_rst_o, 1'h1);
    rd(OFF_CTRL, 32'h00000026);
    rd(OFF_STATUS, STAT_FIXED);
    bus(1'h1, OFF_CTRL, RST_CTRL, 4'hf);
    repeat (12) @(posedge clk_i);
    check(phy_rst_o, 1'h0);
    rd(OFF_STATUS, STAT_FIXED | (32'h1 << STAT_RDY_BIT));
    repeat (2) @(posedge clk_i);
    check(q.size(), 0);
    finish_test();
  end
endmodule
